// ### hdl/eiw_cfg.svh
// eiw_cfg.svh: offsets, field positions, reset values and counts for the pin interrupt block
// assumes: included by bare name after the eiw package
`ifndef EIW_CFG_SVH
`define EIW_CFG_SVH

// line count and register geometry
`define EIW_LINES        16
`define EIW_ADDR_W       12
`define EIW_DATA_W       32
`define EIW_LINE_MSB     15
`define EIW_WORD_LSB     2

// register byte offsets
`define EIW_OFF_ENCLR    12'h008
`define EIW_OFF_ENSET    12'h00C
`define EIW_OFF_FLAG     12'h010
`define EIW_OFF_WAKE     12'h014
`define EIW_OFF_CFG0     12'h018
`define EIW_OFF_CFG1     12'h01C

// reset values
`define EIW_RST_LINES    16'h0000
`define EIW_RST_WORD     32'h0000_0000
`define EIW_RST_SENSE    3'h0

// sense field layout inside a config word
`define EIW_CFG_LINES    8
`define EIW_CFG_STRIDE   4
`define EIW_SENSE_W      3

// input synchroniser depth
`define EIW_SYNC_DEPTH   3

`endif

// ### hdl/eiw_pkg.sv
// eiw_pkg.sv: types shared by the pin interrupt block
// assumes: compiled before any design module
package eiw_pkg;

    // per-line detection select
    typedef enum logic [2:0] {
        EIW_SENSE_NONE = 3'h0,
        EIW_SENSE_RISE = 3'h1,
        EIW_SENSE_FALL = 3'h2,
        EIW_SENSE_BOTH = 3'h3,
        EIW_SENSE_HIGH = 3'h4,
        EIW_SENSE_LOW  = 3'h5,
        EIW_SENSE_RSV6 = 3'h6,
        EIW_SENSE_RSV7 = 3'h7
    } eiw_sense_e;

    // register selected by an APB address
    typedef enum logic [2:0] {
        EIW_REG_NONE  = 3'h0,
        EIW_REG_ENCLR = 3'h1,
        EIW_REG_ENSET = 3'h2,
        EIW_REG_FLAG  = 3'h3,
        EIW_REG_WAKE  = 3'h4,
        EIW_REG_CFG0  = 3'h5,
        EIW_REG_CFG1  = 3'h6
    } eiw_reg_e;

    typedef logic [15:0] eiw_line_t;

endpackage : eiw_pkg

// ### hdl/eiw_ctrl.sv
// eiw_ctrl.sv: pin interrupt enable, flag and wake controller with an APB register slave
// assumes: pins are asynchronous to clk_sys; write lock comes from logic on clk_sys
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps

`include "eiw_cfg.svh"

module eiw_ctrl
    import eiw_pkg::*;
(
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`EIW_ADDR_W-1:0]  paddr,
    input  wire logic [`EIW_DATA_W-1:0]  pwdata,
    output logic      [`EIW_DATA_W-1:0]  prdata,
    output logic                         pready,
    output logic                         pslverr,
    // write protection from the access controller
    input  wire logic                    writeLock,
    // external pins
    input  wire logic [`EIW_LINES-1:0]   pinIrqLine,
    // requests
    output logic                         irqOut,
    output logic                         wakeReq
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic eiw_reg_e decodeReg(input logic [`EIW_ADDR_W-1:0] addr);
        eiw_reg_e sel;
        sel = EIW_REG_NONE;
        unique case (addr)
            `EIW_OFF_ENCLR: sel = EIW_REG_ENCLR;
            `EIW_OFF_ENSET: sel = EIW_REG_ENSET;
            `EIW_OFF_FLAG:  sel = EIW_REG_FLAG;
            `EIW_OFF_WAKE:  sel = EIW_REG_WAKE;
            `EIW_OFF_CFG0:  sel = EIW_REG_CFG0;
            `EIW_OFF_CFG1:  sel = EIW_REG_CFG1;
            default:        sel = EIW_REG_NONE;
        endcase
        return sel;
    endfunction

    // sense match for one line
    function automatic logic senseMatch(input logic [2:0] code, input logic cur,
                                        input logic prev);
        logic hit;
        hit = 1'b0;
        unique case (eiw_sense_e'(code))
            EIW_SENSE_RISE: hit = cur & ~prev;
            EIW_SENSE_FALL: hit = ~cur & prev;
            EIW_SENSE_BOTH: hit = cur ^ prev;
            EIW_SENSE_HIGH: hit = cur;
            EIW_SENSE_LOW:  hit = ~cur;
            default:        hit = 1'b0;
        endcase
        return hit;
    endfunction

    eiw_reg_e                 addrSel;
    logic                     setupPhase;
    logic                     wrAccess;
    logic                     wrProt;
    logic                     wrOk;
    logic                     badAccess;
    logic [`EIW_DATA_W-1:0]   rdWord;
    logic [`EIW_DATA_W-1:0]   prdata_q;
    eiw_line_t                enable_q;
    eiw_line_t                flag_q;
    eiw_line_t                wake_q;
    eiw_line_t                match;
    eiw_line_t                pinLevel_q;
    eiw_line_t                pinPrev_q;
    logic [2:0]               sense_q [`EIW_LINES];
    logic [`EIW_DATA_W-1:0]   cfgWord [2];

    assign addrSel    = decodeReg(paddr);
    assign setupPhase = psel & ~penable;
    assign wrAccess   = psel & penable & pwrite;
    assign wrProt     = (addrSel != EIW_REG_FLAG) && writeLock;
    assign badAccess  = (addrSel == EIW_REG_NONE) || (pwrite && wrProt);
    assign wrOk       = wrAccess & ~badAccess;

    ////////////////////////////////////////////////////////////////////////////
    // apb answer: zero wait states, data captured in the setup cycle

    assign pready  = psel & penable;
    assign pslverr = psel & penable & badAccess;
    assign prdata  = prdata_q;

    always_comb begin
        rdWord = `EIW_RST_WORD;
        unique case (addrSel)
            EIW_REG_ENCLR,
            EIW_REG_ENSET: rdWord = {16'h0000, enable_q};
            EIW_REG_FLAG:  rdWord = {16'h0000, flag_q};
            EIW_REG_WAKE:  rdWord = {16'h0000, wake_q};
            EIW_REG_CFG0:  rdWord = cfgWord[0];
            EIW_REG_CFG1:  rdWord = cfgWord[1];
            default:       rdWord = `EIW_RST_WORD;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_q <= `EIW_RST_WORD;
        end else if (setupPhase && !pwrite) begin
            prdata_q <= rdWord;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and sense decoding

    genvar gi;
    generate
        for (gi = 0; gi < `EIW_LINES; gi++) begin : g_line
            logic [`EIW_SYNC_DEPTH-1:0] sync_q;

            // a change counts once the second and third stages agree
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    sync_q         <= '0;
                    pinLevel_q[gi] <= 1'b0;
                    pinPrev_q[gi]  <= 1'b0;
                end else begin
                    sync_q <= {sync_q[1:0], pinIrqLine[gi]};
                    if (sync_q[1] == sync_q[2]) begin
                        pinLevel_q[gi] <= sync_q[2];
                    end
                    pinPrev_q[gi] <= pinLevel_q[gi];
                end
            end

            assign match[gi] = senseMatch(sense_q[gi], pinLevel_q[gi], pinPrev_q[gi]);

            // sense configuration, write protected
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    sense_q[gi] <= `EIW_RST_SENSE;
                end else if (wrOk && addrSel == ((gi < `EIW_CFG_LINES) ? EIW_REG_CFG0
                                                                      : EIW_REG_CFG1)) begin
                    sense_q[gi] <= pwdata[(gi % `EIW_CFG_LINES) * `EIW_CFG_STRIDE
                                          +: `EIW_SENSE_W];
                end
            end

            assign cfgWord[gi / `EIW_CFG_LINES]
                          [(gi % `EIW_CFG_LINES) * `EIW_CFG_STRIDE +: `EIW_CFG_STRIDE]
                = {1'b0, sense_q[gi]};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // interrupt enables

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enable_q <= `EIW_RST_LINES;
        end else if (wrOk && addrSel == EIW_REG_ENSET) begin
            enable_q <= enable_q | pwdata[`EIW_LINE_MSB:0];
        end else if (wrOk && addrSel == EIW_REG_ENCLR) begin
            enable_q <= enable_q & ~pwdata[`EIW_LINE_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags: a match in the clearing cycle wins

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flag_q <= `EIW_RST_LINES;
        end else if (wrOk && addrSel == EIW_REG_FLAG) begin
            flag_q <= (flag_q & ~pwdata[`EIW_LINE_MSB:0]) | match;
        end else begin
            flag_q <= flag_q | match;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake enables

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wake_q <= `EIW_RST_LINES;
        end else if (wrOk && addrSel == EIW_REG_WAKE) begin
            wake_q <= pwdata[`EIW_LINE_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // requests

    assign irqOut  = |(flag_q & enable_q);
    assign wakeReq = |(match & wake_q);

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    enset_sets_bits_a: assert property (
        wrOk && addrSel == EIW_REG_ENSET |=> ((enable_q & $past(pwdata[15:0]))
                                              == $past(pwdata[15:0])))
        else $error("enable set write did not set bits");

    enset_keeps_bits_a: assert property (
        wrOk && addrSel == EIW_REG_ENSET |=> ((enable_q & $past(enable_q))
                                              == $past(enable_q)))
        else $error("enable set write lost an enable");

    enclr_clears_bits_a: assert property (
        wrOk && addrSel == EIW_REG_ENCLR |=> ((enable_q & $past(pwdata[15:0])) == 16'h0000)
                                             && ((enable_q | $past(pwdata[15:0]))
                                                 == ($past(enable_q) | $past(pwdata[15:0]))))
        else $error("enable clear write wrong");

    enset_read_back_a: assert property (
        setupPhase && !pwrite && addrSel == EIW_REG_ENSET
        |=> prdata == {16'h0000, $past(enable_q)})
        else $error("enable read does not match state");

    match_sets_flag_a: assert property (
        match != 16'h0000 |=> (flag_q & $past(match)) == $past(match))
        else $error("sense match did not set flag");

    flag_clear_w1c_a: assert property (
        wrOk && addrSel == EIW_REG_FLAG
        |=> flag_q == (($past(flag_q) & ~$past(pwdata[15:0])) | $past(match)))
        else $error("flag clear result wrong");

    flag_hold_a: assert property (
        !(wrOk && addrSel == EIW_REG_FLAG) |=> (flag_q & $past(flag_q)) == $past(flag_q))
        else $error("flag dropped without a clear");

    irq_gating_a: assert property (
        irqOut == ((flag_q & enable_q) != 16'h0000))
        else $error("interrupt does not follow flag and enable");

    wake_gating_a: assert property (
        wakeReq |-> ((match & wake_q) != 16'h0000))
        else $error("wake without enabled match");

    wake_write_a: assert property (
        wrOk && addrSel == EIW_REG_WAKE |=> wake_q == $past(pwdata[15:0]))
        else $error("wake enable write not stored");

    lock_protects_a: assert property (
        wrAccess && writeLock && addrSel inside {EIW_REG_ENSET, EIW_REG_ENCLR, EIW_REG_WAKE}
        |=> $stable(enable_q) && $stable(wake_q))
        else $error("locked write changed state");

    reset_zero_a: assert property (
        $past(rst) |-> enable_q == 16'h0000 && flag_q == 16'h0000 && wake_q == 16'h0000)
        else $error("registers not zero after reset");

    upper_zero_a: assert property (
        setupPhase && !pwrite && addrSel inside {EIW_REG_ENSET, EIW_REG_FLAG, EIW_REG_WAKE}
        |=> prdata[31:16] == 16'h0000)
        else $error("upper bits read nonzero");

    enclr_read_back_a: assert property (
        setupPhase && !pwrite && addrSel == EIW_REG_ENCLR
        |=> prdata == {16'h0000, $past(enable_q)})
        else $error("enable clear read does not match state");

    flag_read_back_a: assert property (
        setupPhase && !pwrite && addrSel == EIW_REG_FLAG
        |=> prdata == {16'h0000, $past(flag_q)})
        else $error("flag read does not match state");

    wake_read_back_a: assert property (
        setupPhase && !pwrite && addrSel == EIW_REG_WAKE
        |=> prdata == {16'h0000, $past(wake_q)})
        else $error("wake read does not match state");

    read_data_holds_a: assert property (
        psel && penable && !pwrite |-> prdata == $past(rdWord))
        else $error("read data not the word captured at setup");

    flag_unlocked_a: assert property (
        psel && penable && pwrite && writeLock && addrSel == EIW_REG_FLAG
        |-> !pslverr ##1 (flag_q & $past(pwdata[15:0] & ~match)) == 16'h0000)
        else $error("locked flag clear refused");

    rise_detect_a: assert property (
        sense_q[0] == 3'h1 && pinLevel_q[0] && !pinPrev_q[0] |-> match[0])
        else $error("rising edge not matched");

    reserved_code_a: assert property (
        sense_q[0] inside {3'h0, 3'h6, 3'h7} |-> !match[0])
        else $error("reserved or none code matched");

    // per-line sense and filter checks
    for (gi = 0; gi < `EIW_LINES; gi++) begin : g_chk
        fall_detect_a: assert property (
            sense_q[gi] == EIW_SENSE_FALL && !pinLevel_q[gi] && pinPrev_q[gi] |-> match[gi])
            else $error("falling edge not matched");

        both_detect_a: assert property (
            sense_q[gi] == EIW_SENSE_BOTH && pinLevel_q[gi] != pinPrev_q[gi] |-> match[gi])
            else $error("edge not matched in both mode");

        high_detect_a: assert property (
            sense_q[gi] == EIW_SENSE_HIGH |-> match[gi] == pinLevel_q[gi])
            else $error("high level match wrong");

        low_detect_a: assert property (
            sense_q[gi] == EIW_SENSE_LOW |-> match[gi] == !pinLevel_q[gi])
            else $error("low level match wrong");

        edge_quiet_a: assert property (
            sense_q[gi] inside {EIW_SENSE_RISE, EIW_SENSE_FALL, EIW_SENSE_BOTH}
            && pinLevel_q[gi] == pinPrev_q[gi] |-> !match[gi])
            else $error("edge sense matched a steady pin");

        prev_level_a: assert property (
            pinPrev_q[gi] == $past(pinLevel_q[gi]))
            else $error("previous level not one cycle old");

        filter_agree_a: assert property (
            pinLevel_q[gi] != $past(pinLevel_q[gi])
            |-> $past(g_line[gi].sync_q[1]) == $past(g_line[gi].sync_q[2]))
            else $error("level moved before stages agreed");
    end

endmodule // eiw_ctrl

// ### testbench/eiw_pin_model.sv
// eiw_pin_model.sv: external pad driver standing in for the interrupt pins
// assumes: the bench sets target levels; pads move just after a clk_sys edge
`timescale 1ns/1ps

module eiw_pin_model (
    // clock
    input  wire logic        clk_sys,
    // requested pad levels
    input  wire logic [15:0] pinReq,
    // pads
    output logic      [15:0] pinIrqLine
);
    initial pinIrqLine = 16'h0000;

    always @(posedge clk_sys) begin
        pinIrqLine <= pinReq;
    end
endmodule // eiw_pin_model

// ### testbench/eiw_ctrl_tb.sv
// eiw_ctrl_tb.sv: self-checking bench for the pin interrupt controller
// assumes: apb master here, pads from eiw_pin_model, one clock
`timescale 1ns/1ps

`include "eiw_cfg.svh"

module eiw_ctrl_tb;
    import eiw_pkg::*;

    logic        clk_sys   = 1'b0;
    logic        rst       = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h0000_0000;
    logic        writeLock = 1'b0;
    logic [15:0] pinReq    = 16'h0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] pinIrqLine;
    logic        irqOut;
    logic        wakeReq;
    int          n_mismatch = 0;
    int          checks     = 0;

    localparam logic [7:0] P0  = 8'hAC;
    localparam logic [7:0] EXP = 8'h3E;

    always #4 clk_sys = ~clk_sys;

    eiw_pin_model i_pins (.clk_sys(clk_sys), .pinReq(pinReq), .pinIrqLine(pinIrqLine));

    eiw_ctrl i_dut (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .writeLock(writeLock), .pinIrqLine(pinIrqLine),
        .irqOut(irqOut), .wakeReq(wakeReq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, x, s);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            close_out;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // write checks the error flag; read also compares the data with d
    task automatic acc(input string nm, input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(w, a, d, r, e);
        chk({nm, " err"}, {31'h0, e}, {31'h0, ee});
        if (!w) chk(nm, r, d);
    endtask

    task automatic late(input string nm, ref logic s, input logic x);
        @(negedge clk_sys);
        chk(nm, {31'h0, s}, {31'h0, x});
        @(posedge clk_sys);
    endtask

    task automatic pause;
        repeat (8) @(posedge clk_sys);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        acc("enset", 0, `EIW_OFF_ENSET, 32'h0, 0);
        acc("flag", 0, `EIW_OFF_FLAG, 32'h0, 0);
        acc("wake", 0, `EIW_OFF_WAKE, 32'h0, 0);
        late("irq", irqOut, 1'b0);
    endtask

    task automatic t_enable;
        acc("enset", 1, `EIW_OFF_ENSET, 32'hFFFF_00A5, 0);
        acc("enset", 0, `EIW_OFF_ENSET, 32'h0000_00A5, 0);
        acc("enset", 1, `EIW_OFF_ENSET, 32'h0, 0);
        acc("enset", 0, `EIW_OFF_ENSET, 32'h0000_00A5, 0);
        acc("enclr", 1, `EIW_OFF_ENCLR, 32'h0000_0005, 0);
        acc("enset", 0, `EIW_OFF_ENSET, 32'h0000_00A0, 0);
        writeLock <= 1'b1;
        acc("enset", 1, `EIW_OFF_ENSET, 32'h0000_0001, 1);
        acc("wake", 1, `EIW_OFF_WAKE, 32'h0000_0001, 1);
        acc("enset", 0, `EIW_OFF_ENSET, 32'h0000_00A0, 0);
        acc("wake", 0, `EIW_OFF_WAKE, 32'h0, 0);
        writeLock <= 1'b0;
        acc("enclr", 1, `EIW_OFF_ENCLR, 32'h0000_FFFF, 0);
        acc("enclr", 0, `EIW_OFF_ENCLR, 32'h0, 0);
    endtask

    task automatic t_sense;
        for (int c = 0; c < 8; c++) begin
            pinReq <= {15'h0, P0[c]};
            acc("cfg0", 1, `EIW_OFF_CFG0, {29'h0, 3'(c)}, 0);
            pause;
            acc("flag", 1, `EIW_OFF_FLAG, 32'h0000_FFFF, 0);
            pinReq <= {15'h0, ~P0[c]};
            pause;
            acc("flag", 0, `EIW_OFF_FLAG, {31'h0, EXP[c]}, 0);
        end
    endtask

    task automatic t_irq;
        acc("cfg0", 1, `EIW_OFF_CFG0, {29'h0, EIW_SENSE_RISE}, 0);
        pinReq <= 16'h0000;
        pause;
        acc("flag", 1, `EIW_OFF_FLAG, 32'h0000_FFFF, 0);
        pinReq <= 16'h0001;
        pause;
        late("irq", irqOut, 1'b0);
        acc("flag", 1, `EIW_OFF_FLAG, 32'h0, 0);
        acc("flag", 0, `EIW_OFF_FLAG, 32'h0000_0001, 0);
        acc("enset", 1, `EIW_OFF_ENSET, 32'h0000_0001, 0);
        late("irq", irqOut, 1'b1);
        acc("enclr", 1, `EIW_OFF_ENCLR, 32'h0000_0001, 0);
        late("irq", irqOut, 1'b0);
        acc("enset", 1, `EIW_OFF_ENSET, 32'h0000_0001, 0);
        acc("flag", 1, `EIW_OFF_FLAG, 32'h0000_0001, 0);
        acc("flag", 0, `EIW_OFF_FLAG, 32'h0, 0);
        late("irq", irqOut, 1'b0);
        acc("enclr", 1, `EIW_OFF_ENCLR, 32'h0000_FFFF, 0);
    endtask

    task automatic t_wake;
        acc("wake", 1, `EIW_OFF_WAKE, 32'hFFFF_FFFF, 0);
        acc("wake", 0, `EIW_OFF_WAKE, 32'h0000_FFFF, 0);
        acc("wake", 1, `EIW_OFF_WAKE, 32'h0000_0002, 0);
        pinReq <= 16'h0000;
        acc("cfg0", 1, `EIW_OFF_CFG0, {25'h0, EIW_SENSE_HIGH, 4'h0}, 0);
        pause;
        late("wake", wakeReq, 1'b0);
        pinReq <= 16'h0002;
        pause;
        late("wake", wakeReq, 1'b1);
        acc("wake", 1, `EIW_OFF_WAKE, 32'h0000_0001, 0);
        late("wake", wakeReq, 1'b0);
        pinReq <= 16'h0000;
    endtask

    task automatic t_config;
        acc("cfg1", 1, `EIW_OFF_CFG1, 32'hFFFF_FFFF, 0);
        acc("cfg1", 0, `EIW_OFF_CFG1, 32'h7777_7777, 0);
        writeLock <= 1'b1;
        acc("cfg1", 1, `EIW_OFF_CFG1, 32'h0, 1);
        acc("cfg1", 0, `EIW_OFF_CFG1, 32'h7777_7777, 0);
        writeLock <= 1'b0;
        acc("cfg1", 1, `EIW_OFF_CFG1, 32'h0, 0);
        acc("cfg0", 0, `EIW_OFF_CFG0, {25'h0, EIW_SENSE_HIGH, 4'h0}, 0);
    endtask

    task automatic t_rerun;
        pause;
        acc("enset", 1, `EIW_OFF_ENSET, 32'h0000_0002, 0);
        late("irq", irqOut, 1'b1);
        writeLock <= 1'b1;
        acc("flag", 1, `EIW_OFF_FLAG, 32'h0000_0002, 0);
        acc("flag", 0, `EIW_OFF_FLAG, 32'h0, 0);
        writeLock <= 1'b0;
        pinReq <= 16'h0002;
        pause;
        late("irq", irqOut, 1'b1);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset;
        acc("cfg0", 0, `EIW_OFF_CFG0, 32'h0, 0);
        late("wake", wakeReq, 1'b0);
        pinReq <= 16'h0000;
    endtask

    task automatic t_unmap;
        acc("hole", 0, 12'h020, 32'h0, 1);
        acc("hole", 1, 12'h020, 32'hFFFF_FFFF, 1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset;
        t_enable;
        t_sense;
        t_irq;
        t_wake;
        t_config;
        t_rerun;
        t_unmap;
        close_out;
    end
endmodule // eiw_ctrl_tb
